// [core/rdc_defines.vh]
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH

// ****************************************
// Frames and register offsets
// ****************************************
`define RDC_FRAME_RD 1'b0
`define RDC_FRAME_SGI 1'b1
`define RDC_OFS_PART_LIMITS 16'h0018
`define RDC_OFS_PART_TAGS 16'h001c
`define RDC_OFS_CFG_BASE_LO 16'h0070
`define RDC_OFS_CFG_BASE_HI 16'h0074
`define RDC_OFS_PEND_BASE_LO 16'h0078
`define RDC_OFS_PEND_BASE_HI 16'h007c
`define RDC_OFS_NS_PERM 16'h0e00

// ****************************************
// Access security spaces
// ****************************************
`define RDC_SPACE_SECURE 2'h0
`define RDC_SPACE_NONSECURE 2'h1
`define RDC_SPACE_ROOT 2'h2
`define RDC_SPACE_REALM 2'h3

// ****************************************
// Field positions
// ****************************************
`define RDC_PART_TAG_HI 15
`define RDC_PART_TAG_LO 0
`define RDC_MON_TAG_HI 23
`define RDC_MON_TAG_LO 16
`define RDC_PTZ_BIT 62
`define RDC_OUTER_HI 58
`define RDC_OUTER_LO 56
`define RDC_PA_HI 51
`define RDC_PA_LO 16
`define RDC_SHARE_HI 11
`define RDC_SHARE_LO 10
`define RDC_INNER_HI 9
`define RDC_INNER_LO 7

// ****************************************
// Encodings and reset values
// ****************************************
`define RDC_PERM_NONE 2'h0
`define RDC_PERM_GRP0 2'h1
`define RDC_PERM_BOTH 2'h2
`define RDC_PERM_RSVD 2'h3
`define RDC_SHARE_NONE 2'h0
`define RDC_SHARE_RSVD 2'h3
`define RDC_RST_NS_PERM 32'h00000000
`define RDC_RST_PART_TAGS 32'h00000000
`define RDC_RST_PEND_BASE 64'h0000000000000000

`endif

// [core/rdc_config_regs.v]
// Functional notes
// RULE_01: Sixteen 2-bit permission fields, field x at bits 2x+1:2x.
// RULE_02: Code 00 blocks non-secure generation of secure group 0 and group 1.
// RULE_03: Code 01 lets non-secure generate secure group 0 only.
// RULE_04: Code 10 lets non-secure generate secure group 0 and group 1.
// RULE_05: Reserved 11 acts as 10; reads return the programmed value.
// RULE_06: Permission register governs only software interrupts under affinity routing.
// RULE_07: Permission register RAZ/WI if single security; secure/root RW; others RAZ/WI.
// RULE_08: Partition tags exist only with extended feature and partitioning support.
// RULE_09: Monitor group 23:16 and partition 15:0 tag every access; reset zero.
// RULE_10: Tag bits above those needed for the maximum read zero, ignore writes.
// RULE_11: Pending-table-zero bit 62 is write-only, reads zero, hints table is clear.
// RULE_12: Software clears the pending table before setting the zero hint.
// RULE_13: Outer cacheability 58:56, 000 follows inner, others select outer policy.
// RULE_14: Pending table address bits 51:16; bits above implemented width RAZ/WI.
// RULE_15: Shareability 11:10: 00 none, 01 inner, 10 outer, 11 treated as 00.
// RULE_16: Inner cacheability 9:7: 000 device, 001 non-cacheable, higher allocate policies.
// RULE_17: Outer cacheability and shareability are programmable fields.
// RULE_18: Software leaves the pending base alone while message interrupts are enabled.
// RULE_19: Software programs matching attributes in every redistributor with them enabled.
// RULE_20: Configuration table base register is implemented read-only.
`timescale 1ns/1ps
`default_nettype none
`include "rdc_defines.vh"

module rdc_config_regs #(
   parameter [15:0] PARTITION_MAX = 16'h00ff,
   parameter [7:0] MONITOR_GROUP_MAX = 8'h03,
   parameter integer PA_BITS = 52,
   parameter [63:0] CFG_TABLE_BASE = 64'h0000000000000000
) (
   // Clock, reset, enable
   input wire clk,
   input wire rst_n,
   input wire ce,
   // Register access port
   input wire reg_req,
   input wire reg_write,
   input wire reg_frame,
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire [1:0] reg_space,
   output reg reg_ack,
   output reg [31:0] reg_rdata,
   // Configuration from the rest of the controller
   input wire single_security_state_bit,
   input wire extended_arch_feature,
   input wire partitioning_supported_flag,
   input wire affinity_routing_enabled,
   input wire [15:0] local_group_select,
   input wire [15:0] local_group_modifier,
   input wire [31:0] distributor_ns_permission,
   // Software interrupt generation check
   input wire sgi_req_valid,
   input wire [3:0] sgi_req_id,
   input wire sgi_req_nonsecure,
   output reg sgi_check_done,
   output reg sgi_check_grant,
   // Memory access attributes
   output reg [15:0] partition_tag,
   output reg [7:0] monitor_group_tag,
   output reg [35:0] pend_table_addr,
   output reg [2:0] outer_cache_attr,
   output reg [1:0] pend_share_attr,
   output reg [2:0] inner_cache_attr,
   output reg pending_table_zero_hint
);

   // ****************************************
   // Helpers
   // ****************************************
   // Keeps only the bit positions needed to encode values up to max
   function [15:0] tag_mask;
      input [15:0] max;
      integer i;
      begin
         tag_mask = 16'h0000;
         for (i = 0; i < 16; i = i + 1) begin
            if ((max >> i) != 16'h0000) begin
               tag_mask[i] = 1'b1;
            end
         end
      end
   endfunction

   // Reserved permission code folds onto the widest grant
   function [1:0] eff_perm;
      input [1:0] code;
      begin
         if (code == `RDC_PERM_RSVD) begin
            eff_perm = `RDC_PERM_BOTH; // see RULE_05
         end else begin
            eff_perm = code;
         end
      end
   endfunction

   // Bus fields travel as arguments so every caller follows them as they change
   function sel_addr;
      input [15:0] addr;
      input frame_in;
      input [15:0] ofs;
      input frame;
      begin
         sel_addr = (addr == ofs) && (frame_in == frame);
      end
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   wire [15:0] part_mask;
   wire [15:0] mon_mask_w;
   wire [7:0] mon_mask;
   wire [35:0] pa_mask;
   wire tags_present;
   wire perm_visible;
   wire sel_limits;
   wire sel_tags;
   wire sel_cfg_lo;
   wire sel_cfg_hi;
   wire sel_pend_lo;
   wire sel_pend_hi;
   wire sel_perm;
   wire wr;
   genvar g;

   assign part_mask = tag_mask(PARTITION_MAX);
   assign mon_mask_w = tag_mask({8'h00, MONITOR_GROUP_MAX});
   assign mon_mask = mon_mask_w[7:0];
   assign tags_present = extended_arch_feature & partitioning_supported_flag; // see RULE_08
   assign perm_visible = ~single_security_state_bit &
                         ((reg_space == `RDC_SPACE_SECURE) ||
                          (reg_space == `RDC_SPACE_ROOT)); // see RULE_07
   assign sel_limits = sel_addr(reg_addr, reg_frame, `RDC_OFS_PART_LIMITS, `RDC_FRAME_RD);
   assign sel_tags = sel_addr(reg_addr, reg_frame, `RDC_OFS_PART_TAGS, `RDC_FRAME_RD);
   assign sel_cfg_lo = sel_addr(reg_addr, reg_frame, `RDC_OFS_CFG_BASE_LO, `RDC_FRAME_RD);
   assign sel_cfg_hi = sel_addr(reg_addr, reg_frame, `RDC_OFS_CFG_BASE_HI, `RDC_FRAME_RD);
   assign sel_pend_lo = sel_addr(reg_addr, reg_frame, `RDC_OFS_PEND_BASE_LO, `RDC_FRAME_RD);
   assign sel_pend_hi = sel_addr(reg_addr, reg_frame, `RDC_OFS_PEND_BASE_HI, `RDC_FRAME_RD);
   assign sel_perm = sel_addr(reg_addr, reg_frame, `RDC_OFS_NS_PERM, `RDC_FRAME_SGI);
   assign wr = ce & reg_req & reg_write;

   // Address bits above the implemented width stay zero
   generate
      for (g = 0; g < 36; g = g + 1) begin : g_pa
         assign pa_mask[g] = (g + `RDC_PA_LO) < PA_BITS; // see RULE_14
      end
   endgenerate

   // ****************************************
   // Write strobes
   // ****************************************
   reg [31:0] ns_perm_q;
   reg [1:0] share_q;
   wire perm_wr;
   wire tags_wr;
   wire pend_lo_wr;
   wire pend_hi_wr;

   // Writes that miss a visible register are dropped without trace
   assign perm_wr = wr & sel_perm & perm_visible; // see RULE_07
   assign tags_wr = wr & sel_tags & tags_present; // see RULE_08
   assign pend_lo_wr = wr & sel_pend_lo;
   assign pend_hi_wr = wr & sel_pend_hi;

   // ****************************************
   // Permission register
   // ****************************************
   always @(posedge clk) begin
      if (!rst_n) begin
         ns_perm_q <= `RDC_RST_NS_PERM;
      end else if (perm_wr) begin
         // Reserved codes are kept so software reads back what it wrote
         ns_perm_q <= reg_wdata; // see RULE_01
      end
   end

   // ****************************************
   // Partition and monitor group tags
   // ****************************************
   always @(posedge clk) begin
      if (!rst_n) begin
         partition_tag <= 16'h0000;
         monitor_group_tag <= 8'h00;
      end else if (tags_wr) begin
         partition_tag <= reg_wdata[`RDC_PART_TAG_HI:`RDC_PART_TAG_LO] & part_mask; // see RULE_09
         monitor_group_tag <= reg_wdata[`RDC_MON_TAG_HI:`RDC_MON_TAG_LO] & mon_mask; // see RULE_10
      end
   end

   // ****************************************
   // Pending table base
   // ****************************************
   // No lock while message interrupts run: changing the base then is software's hazard
   always @(posedge clk) begin
      if (!rst_n) begin
         pend_table_addr <= 36'h000000000;
         outer_cache_attr <= 3'h0;
         share_q <= 2'h0;
         pend_share_attr <= 2'h0;
         inner_cache_attr <= 3'h0;
         pending_table_zero_hint <= 1'b0;
      end else begin
         if (pend_lo_wr) begin
            pend_table_addr[15:0] <= reg_wdata[31:16] & pa_mask[15:0]; // see RULE_14
            share_q <= reg_wdata[`RDC_SHARE_HI:`RDC_SHARE_LO]; // see RULE_17
            // Reserved sharing code goes out as non-shareable but reads back as written
            if (reg_wdata[`RDC_SHARE_HI:`RDC_SHARE_LO] == `RDC_SHARE_RSVD) begin
               pend_share_attr <= `RDC_SHARE_NONE; // see RULE_15
            end else begin
               pend_share_attr <= reg_wdata[`RDC_SHARE_HI:`RDC_SHARE_LO];
            end
            inner_cache_attr <= reg_wdata[`RDC_INNER_HI:`RDC_INNER_LO]; // see RULE_16
         end
         if (pend_hi_wr) begin
            pend_table_addr[35:16] <= reg_wdata[`RDC_PA_HI-32:0] & pa_mask[35:16];
            outer_cache_attr <= reg_wdata[`RDC_OUTER_HI-32:`RDC_OUTER_LO-32]; // see RULE_13
            pending_table_zero_hint <= reg_wdata[`RDC_PTZ_BIT-32]; // see RULE_11
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   reg [31:0] rd_d;

   always @* begin
      rd_d = 32'h00000000;
      if (sel_limits && tags_present) begin
         rd_d = {8'h00, MONITOR_GROUP_MAX, PARTITION_MAX};
      end else if (sel_tags && tags_present) begin
         rd_d = {8'h00, monitor_group_tag, partition_tag};
      end else if (sel_cfg_lo) begin
         rd_d = CFG_TABLE_BASE[31:0]; // see RULE_20
      end else if (sel_cfg_hi) begin
         rd_d = CFG_TABLE_BASE[63:32]; // see RULE_20
      end else if (sel_pend_lo) begin
         rd_d = {pend_table_addr[15:0], 4'h0, share_q, inner_cache_attr, 7'h00};
      end else if (sel_pend_hi) begin
         // Zero hint is write-only and never reflected
         rd_d = {5'h00, outer_cache_attr, 4'h0, pend_table_addr[35:16]}; // see RULE_11
      end else if (sel_perm && perm_visible) begin
         rd_d = ns_perm_q; // see RULE_07
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         reg_ack <= 1'b0;
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         reg_ack <= reg_req;
         if (reg_req && !reg_write) begin
            reg_rdata <= rd_d;
         end
      end
   end

   // ****************************************
   // Software interrupt permission check
   // ****************************************
   // Secure group 0 when group and modifier are both clear, group 1 when group clear and modifier set
   reg [1:0] perm_code;
   reg is_sec_g0;
   reg is_sec_g1;
   reg grant_d;

   always @* begin
      if (affinity_routing_enabled) begin
         perm_code = eff_perm(ns_perm_q[2*sgi_req_id +: 2]); // see RULE_06
      end else begin
         perm_code = eff_perm(distributor_ns_permission[2*sgi_req_id +: 2]);
      end
      is_sec_g0 = ~local_group_select[sgi_req_id] & ~local_group_modifier[sgi_req_id];
      is_sec_g1 = ~local_group_select[sgi_req_id] & local_group_modifier[sgi_req_id];
      grant_d = 1'b1;
      if (sgi_req_nonsecure && !single_security_state_bit) begin
         case (perm_code)
            `RDC_PERM_NONE: begin
               grant_d = ~(is_sec_g0 | is_sec_g1); // see RULE_02
            end
            `RDC_PERM_GRP0: begin
               grant_d = ~is_sec_g1; // see RULE_03
            end
            `RDC_PERM_BOTH: begin
               grant_d = 1'b1; // see RULE_04
            end
            default: begin
               grant_d = 1'b1;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         sgi_check_done <= 1'b0;
         sgi_check_grant <= 1'b0;
      end else if (ce) begin
         sgi_check_done <= sgi_req_valid;
         sgi_check_grant <= sgi_req_valid & grant_d;
      end
   end

endmodule

`default_nettype wire

// [sim/rdc_config_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module rdc_config_chk #(
   parameter [15:0] PARTITION_MAX = 16'h00ff,
   parameter [7:0] MONITOR_GROUP_MAX = 8'h03
) (
   // Clock and control
   input wire logic clk, rst_n, ce, single_security_state_bit, affinity_routing_enabled,
   // Register port
   input wire logic reg_req, reg_write, reg_frame, reg_ack,
   input wire logic [15:0] reg_addr,
   input wire logic [1:0] reg_space,
   input wire logic [31:0] reg_rdata,
   // Generation check
   input wire logic sgi_req_valid, sgi_req_nonsecure, sgi_check_done, sgi_check_grant,
   input wire logic [3:0] sgi_req_id,
   input wire logic [15:0] local_group_select, local_group_modifier,
   input wire logic [31:0] distributor_ns_permission,
   // Tags
   input wire logic [15:0] partition_tag,
   input wire logic [7:0] monitor_group_tag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [1:0] dcode = distributor_ns_permission[{sgi_req_id, 1'b0} +: 2];
   wire logic rd = reg_req & ce & !reg_write;
   wire logic sg = sgi_req_valid & ce;
   a_ack_follows_req: assert property (reg_req && ce |=> reg_ack)
      else $error("ack missing");
   a_ack_has_cause: assert property (reg_ack && $past(ce) |-> $past(reg_req))
      else $error("ack without request");
   a_perm_read_zero: assert property (rd && reg_frame && reg_addr == 16'h0e00 &&
      (single_security_state_bit || reg_space[0]) |=> reg_rdata == 32'h0)
      else $error("permission not read as zero");
   a_high_word_zero: assert property (rd && !reg_frame && reg_addr == 16'h007c
      |=> (reg_rdata & 32'hf8f00000) == 32'h0) else $error("high word reserved bits set");
   a_low_word_zero: assert property (rd && !reg_frame && reg_addr == 16'h0078
      |=> (reg_rdata & 32'h0000f07f) == 32'h0) else $error("low word reserved bits set");
   a_check_done: assert property (sg |=> sgi_check_done ##1
      (!sgi_check_done || $past(sg) || !$past(ce))) else $error("check answer missing");
   a_grant_with_done: assert property (sgi_check_grant |-> sgi_check_done)
      else $error("grant without done");
   a_secure_granted: assert property (sg && !sgi_req_nonsecure |=> sgi_check_grant)
      else $error("secure request refused");
   a_ns_blocked: assert property (sg && sgi_req_nonsecure && !single_security_state_bit &&
      !affinity_routing_enabled && !local_group_select[sgi_req_id] && (dcode == 2'h0 ||
      (dcode == 2'h1 && local_group_modifier[sgi_req_id])) |=> !sgi_check_grant)
      else $error("forbidden generation granted");
   a_tag_mask: assert property ((partition_tag & ~PARTITION_MAX) == 16'h0 &&
      (monitor_group_tag & ~MONITOR_GROUP_MAX) == 8'h0) else $error("tag bits above max");
   c_ns_refused: cover property (sg && sgi_req_nonsecure ##1 !sgi_check_grant);
   c_ns_granted: cover property (sg && sgi_req_nonsecure ##1 sgi_check_grant);
   c_back_to_back: cover property (reg_ack [*2]);
endmodule

bind rdc_config_regs rdc_config_chk #(.PARTITION_MAX(PARTITION_MAX),
   .MONITOR_GROUP_MAX(MONITOR_GROUP_MAX)) u_chk (
   .clk(clk), .rst_n(rst_n), .ce(ce), .single_security_state_bit(single_security_state_bit),
   .affinity_routing_enabled(affinity_routing_enabled), .reg_req(reg_req),
   .reg_write(reg_write), .reg_frame(reg_frame), .reg_ack(reg_ack), .reg_addr(reg_addr),
   .reg_space(reg_space), .reg_rdata(reg_rdata), .sgi_req_valid(sgi_req_valid),
   .sgi_req_nonsecure(sgi_req_nonsecure), .sgi_check_done(sgi_check_done),
   .sgi_check_grant(sgi_check_grant), .sgi_req_id(sgi_req_id),
   .local_group_select(local_group_select), .local_group_modifier(local_group_modifier),
   .distributor_ns_permission(distributor_ns_permission), .partition_tag(partition_tag),
   .monitor_group_tag(monitor_group_tag)
);
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rdc_defines.vh"
module tb_top;
   logic clk = 0, rst_n = 0, ce = 1, reg_req = 0, reg_write = 0, reg_frame = 0, reg_ack;
   logic single_security_state_bit = 0, extended_arch_feature = 1;
   logic partitioning_supported_flag = 1, affinity_routing_enabled = 1;
   logic sgi_req_valid = 0, sgi_req_nonsecure = 0, sgi_check_done, sgi_check_grant;
   logic pending_table_zero_hint;
   logic [15:0] reg_addr = 0, local_group_select = 0, local_group_modifier = 0, partition_tag;
   logic [31:0] reg_wdata = 0, reg_rdata, distributor_ns_permission = 0, r, x, c32;
   logic [1:0] reg_space = 0, pend_share_attr, c;
   logic [3:0] sgi_req_id = 0, id;
   logic [7:0] monitor_group_tag;
   logic [35:0] pend_table_addr;
   logic [2:0] outer_cache_attr, inner_cache_attr;
   logic [32:0] rq[$], n;
   logic gq[$];
   logic [31:0] seed = 32'ha1269d1f;
   int bad_count = 0, comparisons = 0, i, j, p;

   // Narrow address width so the upper address bits must read as zero
   rdc_config_regs #(.PA_BITS(48)) dut (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .reg_req(reg_req), .reg_write(reg_write), .reg_frame(reg_frame), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_space(reg_space), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
      .single_security_state_bit(single_security_state_bit),
      .extended_arch_feature(extended_arch_feature),
      .partitioning_supported_flag(partitioning_supported_flag),
      .affinity_routing_enabled(affinity_routing_enabled),
      .local_group_select(local_group_select), .local_group_modifier(local_group_modifier),
      .distributor_ns_permission(distributor_ns_permission),
      .sgi_req_valid(sgi_req_valid), .sgi_req_id(sgi_req_id),
      .sgi_req_nonsecure(sgi_req_nonsecure), .sgi_check_done(sgi_check_done),
      .sgi_check_grant(sgi_check_grant), .partition_tag(partition_tag),
      .monitor_group_tag(monitor_group_tag), .pend_table_addr(pend_table_addr),
      .outer_cache_attr(outer_cache_attr), .pend_share_attr(pend_share_attr),
      .inner_cache_attr(inner_cache_attr), .pending_table_zero_hint(pending_table_zero_hint)
   );

   initial forever #4 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Request stays up so consecutive calls issue back-to-back accesses
   task automatic acc(input logic w, input logic f, input logic [15:0] a,
         input logic [31:0] d, input logic [1:0] s, input logic [31:0] e);
      @(posedge clk);
      #1;
      reg_req = 1;
      reg_write = w;
      reg_frame = f;
      reg_addr = a;
      reg_wdata = d;
      reg_space = s;
      rq.push_back({w, e});
   endtask

   task automatic software_generated_interrupt(input logic [3:0] k, input logic ns, input logic e);
      @(posedge clk);
      #1;
      sgi_req_valid = 1;
      sgi_req_id = k;
      sgi_req_nonsecure = ns;
      gq.push_back(e);
   endtask

   task automatic idle();
      @(posedge clk);
      #1;
      reg_req = 0;
      sgi_req_valid = 0;
      @(posedge clk);
      #1;
   endtask

   // ****************************************
   // Result monitor
   // ****************************************
   always @(negedge clk) begin
      if (reg_ack) begin
         n = rq.pop_front();
         if (!n[32]) chk(reg_rdata, n[31:0]);
      end
      if (sgi_check_done) chk(sgi_check_grant, gq.pop_front());
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      final_report();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      idle();
      chk({monitor_group_tag, partition_tag}, 0);
      acc(0, 1, `RDC_OFS_NS_PERM, 0, `RDC_SPACE_SECURE, 0);
      idle();
      $display("test reset done");
      r = rnd();
      acc(1, 1, `RDC_OFS_NS_PERM, r, `RDC_SPACE_SECURE, 0);
      acc(1, 1, `RDC_OFS_NS_PERM, ~r, `RDC_SPACE_NONSECURE, 0);
      acc(1, 1, `RDC_OFS_NS_PERM, ~r, `RDC_SPACE_REALM, 0);
      for (i = 0; i < 4; i++) acc(0, 1, `RDC_OFS_NS_PERM, 0, i[1:0], i[0] ? 0 : r);
      idle();
      single_security_state_bit = 1;
      acc(1, 1, `RDC_OFS_NS_PERM, ~r, `RDC_SPACE_SECURE, 0);
      acc(0, 1, `RDC_OFS_NS_PERM, 0, `RDC_SPACE_SECURE, 0);
      idle();
      single_security_state_bit = 0;
      acc(0, 1, `RDC_OFS_NS_PERM, 0, `RDC_SPACE_ROOT, r);
      idle();
      $display("test permission access done");
      for (p = 0; p < 3; p++) begin
         affinity_routing_enabled = (p == 0);
         single_security_state_bit = (p == 2);
         distributor_ns_permission = rnd();
         x = rnd();
         local_group_select = x[15:0];
         local_group_modifier = x[31:16];
         for (j = 0; j < 24; j++) begin
            x = rnd();
            id = x[3:0];
            c32 = (p == 0 ? r : distributor_ns_permission) >> {id, 1'b0};
            c = c32[1:0];
            software_generated_interrupt(id, x[4], (p == 2) | !x[4] | local_group_select[id] | c[1] |
               (c == 2'h1 & !local_group_modifier[id]));
         end
         idle();
      end
      single_security_state_bit = 0;
      $display("test generation check done");
      r = rnd();
      acc(1, 0, `RDC_OFS_PART_TAGS, r, 0, 0);
      acc(0, 0, `RDC_OFS_PART_TAGS, 0, 0, r & 32'h000300ff);
      idle();
      chk({monitor_group_tag, partition_tag}, r[23:0] & 24'h0300ff);
      partitioning_supported_flag = 0;
      acc(1, 0, `RDC_OFS_PART_TAGS, 0, 0, 0);
      acc(0, 0, `RDC_OFS_PART_TAGS, 0, 0, 0);
      acc(0, 0, `RDC_OFS_PART_LIMITS, 0, 0, 0);
      idle();
      chk({monitor_group_tag, partition_tag}, r[23:0] & 24'h0300ff);
      partitioning_supported_flag = 1;
      acc(0, 0, `RDC_OFS_PART_LIMITS, 0, 0, 32'h000300ff);
      idle();
      // A request while the clock enable is low must leave no trace
      ce = 0;
      reg_req = 1;
      reg_write = 1;
      reg_frame = `RDC_FRAME_RD;
      reg_addr = `RDC_OFS_PART_TAGS;
      reg_wdata = ~r;
      idle();
      ce = 1;
      chk({monitor_group_tag, partition_tag}, r[23:0] & 24'h0300ff);
      $display("test tags done");
      r = rnd();
      x = rnd() | 32'h40000000;
      acc(1, 0, `RDC_OFS_PEND_BASE_LO, r, 0, 0);
      acc(1, 0, `RDC_OFS_PEND_BASE_HI, x, 0, 0);
      acc(0, 0, `RDC_OFS_PEND_BASE_LO, 0, 0, r & 32'hffff0f80);
      acc(0, 0, `RDC_OFS_PEND_BASE_HI, 0, 0, x & 32'h0700ffff);
      acc(0, 0, 16'h0040, 0, 0, 0);
      idle();
      c = (r[11:10] == `RDC_SHARE_RSVD) ? `RDC_SHARE_NONE : r[11:10];
      chk({pend_table_addr, outer_cache_attr, pend_share_attr, inner_cache_attr,
         pending_table_zero_hint}, {4'h0, x[15:0], r[31:16], x[26:24], c, r[9:7], 1'b1});
      // Reserved sharing code goes out as non-shareable yet reads back as written
      acc(1, 0, `RDC_OFS_PEND_BASE_LO, r | 32'h00000c00, 0, 0);
      acc(0, 0, `RDC_OFS_PEND_BASE_LO, 0, 0, (r | 32'h00000c00) & 32'hffff0f80);
      idle();
      chk(pend_share_attr, `RDC_SHARE_NONE);
      acc(1, 0, `RDC_OFS_PEND_BASE_HI, x & 32'hbfffffff, 0, 0);
      idle();
      chk(pending_table_zero_hint, 0);
      $display("test pending base done");
      final_report();
   end
endmodule
`default_nettype wire
